// ---- sfp_fault_former.v ----
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "sfp_regs.vh"
module sfp_fault_former #(
  parameter WORD_W = 48,
  parameter IDX_W  = 20
) (
  input  wire              clock,
  input  wire              reset_n,
  input  wire [11:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire              hsel,
  input  wire              hready,
  input  wire [31:0]       hwdata,
  output reg  [31:0]       hrdata,
  output wire              hreadyout,
  output wire              hresp,
  input  wire              opValid,
  input  wire [7:0]        opcode,
  input  wire [2:0]        strobe,
  input  wire [10:0]       seqStep,
  input  wire              seqMicro,
  input  wire              stream_op_flag,
  input  wire              table_edit_flag,
  input  wire              editMode,
  input  wire              variantMode,
  input  wire              retryFf,
  input  wire              pointersAdjusted,
  input  wire              writeOp,
  input  wire              descReadOnly,
  input  wire              flashProtect,
  input  wire [WORD_W-1:0] descWord,
  input  wire              tagMismatch,
  input  wire              divideOp,
  input  wire              divisorZero,
  input  wire              expOverflow,
  input  wire              expSign,
  input  wire              indexOp,
  input  wire [IDX_W-1:0]  indexValue,
  input  wire [IDX_W-1:0]  descLength,
  input  wire              integerizeOvf,
  input  wire              pseudoCalled,
  input  wire              exitReturnOp,
  input  wire              atStackBase,
  input  wire [WORD_W-1:0] return_control_word,
  input  wire              descAccess,
  input  wire              dataAbsent,
  input  wire              pbVectorStack,
  input  wire              pbReturnEscape,
  input  wire              markAccess,
  input  wire [2:0]        markTag,
  input  wire [IDX_W-1:0]  stackPtr,
  input  wire [IDX_W-1:0]  stack_limit_reg,
  input  wire              joinFault,
  input  wire [WORD_W-1:0] joinRestartCount,
  input  wire              segArrayWord,
  input  wire [WORD_W-1:0] memWord,
  input  wire              timerExpired,
  input  wire              confidenceErr,
  output reg               faultValid,
  output reg  [WORD_W-1:0] first_param_word,
  output reg  [WORD_W-1:0] second_param_word,
  output reg  [WORD_W-1:0] third_param_word,
  output reg  [WORD_W-1:0] topA,
  output reg  [WORD_W-1:0] topB,
  output reg               suppressWrite,
  output reg               restoreFlash,
  output reg               backupPointers,
  output reg               terminateCaller
);

  // control, status and capture state
  reg  [2:0]        ctrl;           // bit0 enable, bit1 hold after a fault
  reg               held;
  reg               wrStb;
  reg  [11:0]       wrAddr;
  reg  [13:0]       cause;
  reg  [WORD_W-1:0] p1;
  reg  [WORD_W-1:0] p2;
  reg  [WORD_W-1:0] p3;
  // next values
  reg  [WORD_W-1:0] next_topA;
  reg  [WORD_W-1:0] next_topB;
  reg               next_held;
  reg               next_suppress;
  reg               next_restore;
  reg               next_backup;
  reg               next_terminate;
  reg  [31:0]       next_hrdata;

  // all conditions are levels from operator logic on this same clock, so they
  // need no synchroniser; a cause must stand in the cycle it is to be taken
  // a read-only descriptor ends the store before memory is touched
  wire protReadOnly  = writeOp && descReadOnly;
  wire protFlash     = writeOp && flashProtect;
  wire programmedOp  = opValid && (opcode == `SFP_OPC_INVALID);
  wire badTag        = tagMismatch;
  wire divByZero     = divideOp && divisorZero;
  wire expHigh       = expOverflow && !expSign;
  wire expLow        = expOverflow && expSign;
  wire indexNegative = indexOp && indexValue[IDX_W-1];
  wire indexTooLarge = indexOp && (indexValue >= descLength);
  wire intOverflow   = integerizeOvf;
  wire stackBase     = exitReturnOp && atStackBase;
  wire absentData    = descAccess && dataAbsent;
  wire badMarkTag    = markAccess && (markTag != `SFP_TAG_MARK);
  wire arrayBound    = segArrayWord;
  wire timerOut      = timerExpired;
  // a plain compare: it refires every cycle unless the hold bit is used
  wire stackFull     = (stackPtr == stack_limit_reg);
  wire confFail      = confidenceErr;

  // cause vector, one bit per fault kind at its first-word position
  always @* begin
    cause                   = 14'h0000;
    cause[`SFP_P1_MEMPROT]  = protReadOnly || protFlash;
    cause[`SFP_P1_INVOPND]  = badTag || programmedOp;
    cause[`SFP_P1_DIVZERO]  = divByZero;
    cause[`SFP_P1_EXPOVF]   = expHigh;
    cause[`SFP_P1_EXPUNF]   = expLow;
    cause[`SFP_P1_INVINDEX] = indexNegative || indexTooLarge;
    cause[`SFP_P1_INTOVF]   = intOverflow;
    cause[`SFP_P1_BASESTK]  = stackBase;
    cause[`SFP_P1_PRESENCE] = absentData;
    cause[`SFP_P1_SEQERR]   = badMarkTag;
    cause[`SFP_P1_SEGARRAY] = arrayBound;
    cause[`SFP_P1_TIMER]    = timerOut;
    cause[`SFP_P1_STKOVF]   = stackFull;
    cause[`SFP_P1_CONFERR]  = confFail;
  end

  // a refused fault (disabled or held) leaves every output untouched
  wire causeAny    = |cause;
  wire enabled     = ctrl[0];
  wire anyFault    = enabled && !held && causeAny;
  wire presence    = cause[`SFP_P1_PRESENCE];
  wire arithStop   = cause[`SFP_P1_DIVZERO] || cause[`SFP_P1_EXPOVF] ||
                     cause[`SFP_P1_EXPUNF];
  wire stackHit    = cause[`SFP_P1_BASESTK];
  wire protHit     = cause[`SFP_P1_MEMPROT];
  wire statusClear = wrStb && (wrAddr == `SFP_OFF_STATUS) && hwdata[0];
  wire ctrlWrite   = wrStb && (wrAddr == `SFP_OFF_CTRL);

  // presence encoding: 46 value call, 45 return escape, 39 vector stack
  wire pbCall      = presence && !pbVectorStack;
  wire pbReturn    = presence && pbReturnEscape;
  wire pbVector    = presence && pbVectorStack;
  // class: 10 before the pointers move (consistent), 01 after; never both
  wire classHi     = !pointersAdjusted;
  wire classLo     = pointersAdjusted;

  // first parameter word
  always @* begin
    p1                   = {WORD_W{1'b0}};
    p1[13:0]             = cause;
    // the programmed operator has no bit of its own and shows as invalid operand
    p1[`SFP_P1_RETRY]    = retryFf;
    p1[`SFP_P1_CLASS_HI] = classHi;
    p1[`SFP_P1_CLASS_LO] = classLo;
    p1[`SFP_P1_VECTOR]   = stream_op_flag;
    p1[`SFP_P1_PB_VCALL] = pbCall;
    p1[`SFP_P1_PB_RET]   = pbReturn;
    p1[`SFP_P1_PB_VS]    = pbVector;
  end

  // second parameter word; a join fault rides on a string fault and wins
  always @* begin
    p2 = {WORD_W{1'b0}};
    if (joinFault) begin
      p2 = joinRestartCount;
    end else if (segArrayWord) begin
      p2 = memWord;
    end
  end

  // third parameter word; the sequence field's meaning follows the moded bit
  // fields above bit 27 stay zero
  always @* begin
    p3                          = {WORD_W{1'b0}};
    p3[`SFP_P3_SEQ_LSB +: 11]   = seqStep;
    p3[`SFP_P3_MODED]           = seqMicro;
    p3[`SFP_P3_STROBE_LSB +: 3] = strobe;
    p3[`SFP_P3_OPC_LSB +: 8]    = opcode;
    p3[`SFP_P3_VARIANT]         = variantMode;
    p3[`SFP_P3_EDIT]            = editMode;
    p3[`SFP_P3_TEDIT]           = table_edit_flag;
    p3[`SFP_P3_VECTOR]          = stream_op_flag;
  end

  // top-of-stack state left behind by the fault
  always @* begin
    next_topA = topA;
    next_topB = topB;
    if (arithStop) begin
      next_topA = {WORD_W{1'b0}};
      next_topB = p1;
    end else if (stackHit) begin
      next_topA = return_control_word;
    end else if (protHit) begin
      next_topA = descWord;
    end
  end

  // a fault and a status clear in one cycle: while held the fault is refused and the clear wins; if not held, held takes ctrl[1]
  always @* begin
    next_held = held;
    if (anyFault) begin
      next_held = ctrl[1];
    end else if (statusClear) begin
      next_held = 1'b0;
    end
  end

  // side-effect pulses ride along with the capture strobe
  always @* begin
    next_suppress  = 1'b0;
    next_restore   = 1'b0;
    next_backup    = 1'b0;
    next_terminate = 1'b0;
    if (anyFault) begin
      next_suppress  = protHit;
      next_restore   = protFlash && !descReadOnly;
      next_backup    = cause[`SFP_P1_DIVZERO];
      next_terminate = intOverflow && pseudoCalled;
    end
  end

  // capture strobe and side-effect pulses, one cycle each
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      faultValid      <= 1'b0;
      suppressWrite   <= 1'b0;
      restoreFlash    <= 1'b0;
      backupPointers  <= 1'b0;
      terminateCaller <= 1'b0;
    end else begin
      faultValid      <= anyFault;
      suppressWrite   <= next_suppress;
      restoreFlash    <= next_restore;
      backupPointers  <= next_backup;
      terminateCaller <= next_terminate;
    end
  end

  // held blocks further captures until software clears it
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      held <= 1'b0;
    end else begin
      held <= next_held;
    end
  end

  // parameter words stand until the next capture;
  // a refused fault keeps the last captured set
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      first_param_word  <= {WORD_W{1'b0}};
      second_param_word <= {WORD_W{1'b0}};
      third_param_word  <= {WORD_W{1'b0}};
    end else if (anyFault) begin
      first_param_word  <= p1;
      second_param_word <= p2;
      third_param_word  <= p3;
    end
  end

  // the top registers move only on a capture
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      topA <= {WORD_W{1'b0}};
      topB <= {WORD_W{1'b0}};
    end else if (anyFault) begin
      topA <= next_topA;
      topB <= next_topB;
    end
  end

  // ahb-lite slave with no wait states: read data is registered in the address
  // phase and stands through the data phase
  wire take   = hsel && hready && htrans[1];
  wire rdTake = take && !hwrite;
  wire wrTake = take && hwrite;

  // register views; upper halves are zero-extended
  wire [31:0] ctrlView   = {29'h0000_0000, ctrl};
  wire [31:0] statusView = {30'h0000_0000, faultValid, held};
  wire [31:0] p1Lo       = first_param_word[31:0];
  wire [31:0] p1Hi       = {16'h0000, first_param_word[47:32]};
  wire [31:0] p2Lo       = second_param_word[31:0];
  wire [31:0] p2Hi       = {16'h0000, second_param_word[47:32]};
  wire [31:0] p3Lo       = third_param_word[31:0];
  wire [31:0] p3Hi       = {16'h0000, third_param_word[47:32]};
  wire [31:0] topALo     = topA[31:0];
  wire [31:0] topAHi     = {16'h0000, topA[47:32]};
  wire [31:0] topBLo     = topB[31:0];
  wire [31:0] topBHi     = {16'h0000, topB[47:32]};

  // a write lands at the end of its data phase
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrStb  <= 1'b0;
      wrAddr <= 12'h000;
    end else begin
      wrStb  <= wrTake;
      wrAddr <= haddr;
    end
  end

  // enable comes out of reset set, so faults are taken without any setup
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= 3'h1;
    end else if (ctrlWrite) begin
      ctrl <= hwdata[2:0];
    end
  end

  // read mux, decoded on the address phase
  always @* begin
    next_hrdata = 32'h0000_0000;
    case (haddr)
      `SFP_OFF_CTRL:    next_hrdata = ctrlView;
      `SFP_OFF_STATUS:  next_hrdata = statusView;
      `SFP_OFF_P1_LO:   next_hrdata = p1Lo;
      `SFP_OFF_P1_HI:   next_hrdata = p1Hi;
      `SFP_OFF_P2_LO:   next_hrdata = p2Lo;
      `SFP_OFF_P2_HI:   next_hrdata = p2Hi;
      `SFP_OFF_P3_LO:   next_hrdata = p3Lo;
      `SFP_OFF_P3_HI:   next_hrdata = p3Hi;
      `SFP_OFF_TOPA_LO: next_hrdata = topALo;
      `SFP_OFF_TOPA_HI: next_hrdata = topAHi;
      `SFP_OFF_TOPB_LO: next_hrdata = topBLo;
      `SFP_OFF_TOPB_HI: next_hrdata = topBHi;
      default:          next_hrdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rdTake) begin
      hrdata <= next_hrdata;
    end
  end

  // every transfer is a whole word with an okay response
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule // sfp_fault_former

// ---- sfp_fault_former_properties.sv ----
`timescale 1ns/1ps
module sfp_fault_former_properties #(
  parameter WORD_W = 48,
  parameter IDX_W  = 20
) (
  input wire logic clock, reset_n, faultValid, backupPointers, suppressWrite, restoreFlash,
  input wire logic retryFf, stream_op_flag, pointersAdjusted, seqMicro, expOverflow, expSign,
  input wire logic [7:0]        opcode,
  input wire logic [2:0]        strobe,
  input wire logic [10:0]       seqStep,
  input wire logic [IDX_W-1:0]  stackPtr, stack_limit_reg,
  input wire logic [WORD_W-1:0] return_control_word, first_param_word, third_param_word,
  input wire logic [WORD_W-1:0] topA, topB
);
  wire [WORD_W-1:0] p1 = first_param_word;
  wire [WORD_W-1:0] p3 = third_param_word;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence arith_stop; faultValid && (p1[2] || p1[3] || p1[4]); endsequence
  sequence prot_seen; faultValid && restoreFlash; endsequence
  class_bits_a: assert property (faultValid |-> p1[23] == $past(pointersAdjusted)
    && p1[24] == !p1[23]) else $error("class bits wrong");
  vector_flag_a: assert property (faultValid |-> p1[44] == $past(stream_op_flag))
    else $error("vector flag wrong");
  retry_copy_a: assert property (faultValid |-> p1[19] == $past(retryFf))
    else $error("retry bit wrong");
  op_fields_a: assert property (faultValid |-> p3[23:16] == $past(opcode)
    && p3[15:13] == $past(strobe) && p3[12] == $past(seqMicro) && p3[10:0] == $past(seqStep))
    else $error("third word fields wrong");
  arith_top_a: assert property (arith_stop |-> topA == '0 && topB == p1)
    else $error("top registers wrong after arithmetic stop");
  div_backup_a: assert property (faultValid && p1[2] |-> backupPointers)
    else $error("pointers not backed up");
  exp_sign_a: assert property (faultValid && $past(expOverflow) |-> p1[4] == $past(expSign)
    && p1[3] != p1[4]) else $error("exponent direction wrong");
  stack_eq_a: assert property (faultValid && p1[12] |-> $past(stackPtr == stack_limit_reg))
    else $error("stack overflow without limit match");
  prot_store_a: assert property (prot_seen |-> suppressWrite && p1[0])
    else $error("protected store not suppressed");
  base_stack_a: assert property (faultValid && p1[7] |-> topA == $past(return_control_word))
    else $error("return word not on top");
endmodule // sfp_fault_former_properties
bind sfp_fault_former sfp_fault_former_properties #(.WORD_W(WORD_W), .IDX_W(IDX_W)) u_props (.*);

// ---- sfp_fault_former_tb_top.sv ----
`timescale 1ns/1ps
module sfp_fault_former_tb_top;
  logic clock = 0, reset_n = 0, go = 0, hwrite = 0, hsel = 0, opValid = 0, seqMicro = 0;
  logic stream_op_flag = 0, table_edit_flag = 0, editMode = 0, variantMode = 0;
  logic retryFf = 0, pointersAdjusted = 0, joinFault = 0;
  logic [1:0] htrans = 0;
  logic [11:0] haddr = 0;
  logic [31:0] hwdata = 0, rd;
  logic [3:0] kind = 0;
  logic [47:0] rnd = 0, lastP1;
  logic [7:0] opcode = 0;
  logic [2:0] strobe = 0;
  logic [10:0] seqStep = 0;
  int err_count = 0, num_checks = 0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, faultValid, suppressWrite, restoreFlash, backupPointers, terminateCaller;
  wire writeOp, descReadOnly, flashProtect, tagMismatch, divideOp, divisorZero, expOverflow;
  wire expSign, indexOp, integerizeOvf, pseudoCalled, exitReturnOp, atStackBase, descAccess;
  wire dataAbsent, pbVectorStack, pbReturnEscape, markAccess, segArrayWord, timerExpired;
  wire confidenceErr;
  wire [2:0] markTag;
  wire [19:0] indexValue, descLength, stackPtr, stack_limit_reg;
  wire [47:0] descWord, return_control_word, memWord, joinRestartCount, topA, topB;
  wire [47:0] first_param_word, second_param_word, third_param_word;
  sfp_op_model u_model (.*);
  sfp_fault_former u_dut (.*, .hsize(3'h2), .hready(hreadyout));
  always #20 clock = ~clock;
  task automatic ck(input string n, input logic [47:0] e, input logic [47:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    ck("hresp", 0, hresp);
  endtask
  task automatic fire(input int k, input logic en);
    logic [47:0] r, e, m;
    logic [31:0] w;
    logic [7:0] oc;
    r = {$urandom, $urandom};
    w = $urandom;
    // an opcode of all ones would raise a second cause
    oc = (k == 15) ? 8'hFF : w[31:24] % 8'hFF;
    @(posedge clock);
    rnd <= r;
    kind <= k[3:0];
    go <= 1;
    opValid <= 1;
    opcode <= oc;
    {variantMode, editMode, table_edit_flag, stream_op_flag, retryFf} <= w[4:0];
    pointersAdjusted <= w[5];
    seqMicro <= w[6];
    strobe <= w[9:7];
    seqStep <= w[20:10];
    joinFault <= (k == 10) && w[21];
    @(posedge clock);
    go <= 0;
    opValid <= 0;
    joinFault <= 0;
    #1;
    ck("faultValid", {47'h0, en}, {47'h0, faultValid});
    if (en) begin
      e = '0;
      e[(k > 13) ? k - 14 : k] = 1'b1;
      {e[44], e[19], e[24], e[23]} = {w[1], w[0], !w[5], w[5]};
      if (k == 8) {e[46], e[45], e[39]} = {!r[5], r[4], r[5]};
      // presence cause bits mean nothing for the other kinds
      m = (k == 8) ? '1 : ~48'h6080_0000_0000;
      lastP1 = e;
      ck("p1", e & m, first_param_word & m);
      ck("p3", {20'h0, w[1], w[2], w[3], w[4], oc, w[9:6], 1'b0, w[20:10]},
         third_param_word & ~48'h800);
      if (k >= 2 && k <= 4) ck("topB", e & m, topB & m);
      if (k >= 2 && k <= 4) ck("topA", '0, topA);
      if (k == 2) ck("backup", 1, backupPointers);
      if (k == 0 || k == 7 || k == 14) ck("topA", r, topA);
      if (k == 0) ck("prot", 2, {suppressWrite, restoreFlash});
      if (k == 10) ck("p2", w[21] ? ~r : r, second_param_word);
      if (k == 14) ck("flash", 3, {suppressWrite, restoreFlash});
      if (k == 6) ck("terminate", r[3], terminateCaller);
    end
  endtask
  task automatic end_of_test;
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    void'($urandom(39));
    repeat (10) @(posedge clock);
    reset_n <= 1;
    bus(0, 12'h000, 0);
    ck("ctrl", 1, rd);
    bus(0, 12'h030, 0);
    ck("unmapped", 0, rd);
    for (int i = 0; i < 48; i++) fire(i % 16, 1);
    bus(0, 12'h008, 0);
    ck("p1 low", lastP1[31:0], rd);
    bus(1, 12'h000, 32'h0000_0003);
    fire(12, 1);
    fire(2, 0);
    bus(0, 12'h004, 0);
    ck("status", 1, rd);
    bus(1, 12'h004, 32'h0000_0001);
    bus(1, 12'h000, 32'h0000_0000);
    fire(3, 0);
    bus(1, 12'h000, 32'h0000_0001);
    fire(3, 1);
    end_of_test;
  end
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    end_of_test;
  end
endmodule // sfp_fault_former_tb_top

// ---- sfp_op_model.sv ----
`timescale 1ns/1ps
module sfp_op_model (
  input  wire logic        go,
  input  wire logic [3:0]  kind,
  input  wire logic [47:0] rnd,
  output logic writeOp, descReadOnly, flashProtect, tagMismatch, divideOp, divisorZero,
  output logic expOverflow, expSign, indexOp, integerizeOvf, pseudoCalled, exitReturnOp,
  output logic atStackBase, descAccess, dataAbsent, pbVectorStack, pbReturnEscape,
  output logic markAccess, segArrayWord, timerExpired, confidenceErr,
  output logic [2:0]  markTag,
  output logic [19:0] indexValue, descLength, stackPtr, stack_limit_reg,
  output logic [47:0] descWord, return_control_word, memWord, joinRestartCount
);
  wire [15:0] hit = {15'h0, go} << kind;
  assign writeOp = hit[0] | hit[14];
  assign descReadOnly = hit[0];
  assign flashProtect = hit[14];
  assign tagMismatch = hit[1];
  assign divideOp = hit[2];
  assign divisorZero = hit[2];
  assign expOverflow = hit[3] | hit[4];
  assign expSign = hit[4];
  assign indexOp = hit[5];
  // either a negative index or one sitting exactly on the length
  assign indexValue = rnd[6] ? {1'b1, rnd[18:0]} : 20'h0_0040;
  assign descLength = 20'h0_0040;
  assign integerizeOvf = hit[6];
  assign pseudoCalled = hit[6] & rnd[3];
  assign exitReturnOp = hit[7];
  assign atStackBase = hit[7];
  assign descAccess = hit[8];
  assign dataAbsent = hit[8];
  assign pbVectorStack = rnd[5];
  // the handler resumes the faulting operator, either escape is legal
  assign pbReturnEscape = rnd[4];
  assign markAccess = hit[9];
  // a mark word with a tag of 4 to 7, never the legal one
  assign markTag = hit[9] ? {1'b1, rnd[1:0]} : 3'h3;
  assign segArrayWord = hit[10];
  assign timerExpired = hit[11];
  // the compare is continuous, so limit only meets the pointer inside a request
  assign stackPtr = 20'h0_0100;
  assign stack_limit_reg = hit[12] ? 20'h0_0100 : 20'h0_0200;
  assign confidenceErr = hit[13];
  assign descWord = rnd;
  assign return_control_word = rnd;
  assign memWord = rnd;
  // inverted so that a join count can be told apart from the segment word
  assign joinRestartCount = ~rnd;
endmodule // sfp_op_model

// ---- sfp_regs.vh ----
`ifndef SFP_REGS_VH
`define SFP_REGS_VH
// register byte offsets
`define SFP_OFF_CTRL     12'h000
`define SFP_OFF_STATUS   12'h004
`define SFP_OFF_P1_LO    12'h008
`define SFP_OFF_P1_HI    12'h00C
`define SFP_OFF_P2_LO    12'h010
`define SFP_OFF_P2_HI    12'h014
`define SFP_OFF_P3_LO    12'h018
`define SFP_OFF_P3_HI    12'h01C
`define SFP_OFF_TOPA_LO  12'h020
`define SFP_OFF_TOPA_HI  12'h024
`define SFP_OFF_TOPB_LO  12'h028
`define SFP_OFF_TOPB_HI  12'h02C
// first parameter word bit positions
`define SFP_P1_MEMPROT   0
`define SFP_P1_INVOPND   1
`define SFP_P1_DIVZERO   2
`define SFP_P1_EXPOVF    3
`define SFP_P1_EXPUNF    4
`define SFP_P1_INVINDEX  5
`define SFP_P1_INTOVF    6
`define SFP_P1_BASESTK   7
`define SFP_P1_PRESENCE  8
`define SFP_P1_SEQERR    9
`define SFP_P1_SEGARRAY  10
`define SFP_P1_TIMER     11
`define SFP_P1_STKOVF    12
`define SFP_P1_CONFERR   13
`define SFP_P1_RETRY     19
`define SFP_P1_CLASS_LO  23
`define SFP_P1_CLASS_HI  24
`define SFP_P1_PB_VS     39
`define SFP_P1_VECTOR    44
`define SFP_P1_PB_RET    45
`define SFP_P1_PB_VCALL  46
// third parameter word fields
`define SFP_P3_SEQ_LSB   0
`define SFP_P3_MODED     12
`define SFP_P3_STROBE_LSB 13
`define SFP_P3_OPC_LSB   16
`define SFP_P3_VARIANT   24
`define SFP_P3_EDIT      25
`define SFP_P3_TEDIT     26
`define SFP_P3_VECTOR    27
// operator codes and tags
`define SFP_OPC_INVALID  8'hFF
`define SFP_TAG_MARK     3'h3
`endif
